// ---- inc/ioc_defs.svh ----
// Register offsets, field positions, codes and reset values of the I/O command block.
// Assumes 8-bit byte addresses on the register port and 16-bit signed references.
`ifndef IOC_DEFS_SVH
`define IOC_DEFS_SVH

// Register offsets
`define IOC_ADDR_CMD_CFG 8'h00
`define IOC_ADDR_SPD_CFG 8'h04
`define IOC_ADDR_TRQ_CFG 8'h08
`define IOC_ADDR_STATUS 8'h0c
`define IOC_ADDR_SPD_REF 8'h10
`define IOC_ADDR_TRQ_REF 8'h14

// Command configuration fields
`define IOC_F_START_SEL 3:0
`define IOC_F_REV_SEL 7:4
`define IOC_F_RST_SEL 11:8
`define IOC_F_TOG_SEL 15:12
`define IOC_F_START_MODE 17:16

// Combiner configuration fields
`define IOC_F_SRC1 2:0
`define IOC_F_SRC2 6:4
`define IOC_F_LOGIC 11:8
`define IOC_F_TRQ_LOGIC 10:8

// Status fields
`define IOC_B_START 0
`define IOC_B_REV 1
`define IOC_B_FRST 2
`define IOC_B_TOG 3
`define IOC_F_DI 15:8

// Start modes
`define IOC_MODE_LEVEL 2'h0
`define IOC_MODE_EDGE 2'h1
`define IOC_MODE_PULSE 2'h2

// Source codes
`define IOC_SRC_NONE 3'h0
`define IOC_SRC_FIELDBUS 3'h2
`define IOC_SRC_IO1 3'h3
`define IOC_SRC_IO2 3'h4
`define IOC_SRC_PRESET 3'h5

// Combination codes
`define IOC_LOGIC_SRC1 4'h0
`define IOC_LOGIC_SRC2 4'h1
`define IOC_LOGIC_SUM 4'h2
`define IOC_LOGIC_SUB 4'h3
`define IOC_LOGIC_DIV 4'h4
`define IOC_LOGIC_MUL 4'h5
`define IOC_LOGIC_MAX 4'h6
`define IOC_LOGIC_MIN 4'h7
`define IOC_LOGIC_TOGGLE 4'h8

// Widths and limits
`define IOC_DI_W 8
`define IOC_REF_MAX 32'sh00007fff
`define IOC_REF_MIN 32'shffff8000

// Reset values
`define IOC_RST_START_MODE `IOC_MODE_LEVEL
`define IOC_RST_DI_SEL 4'h0
`define IOC_RST_SRC1 `IOC_SRC_IO1
`define IOC_RST_SRC2 `IOC_SRC_NONE
`define IOC_RST_LOGIC `IOC_LOGIC_SRC1

`endif

// ---- inc/ioc_pkg.sv ----
// Types and shared helpers of the I/O command block.
// Assumes ioc_defs.svh is on the include path.
`include "ioc_defs.svh"

package ioc_pkg;

	typedef logic signed [15:0] ioc_ref_t;

	typedef struct packed {
		ioc_ref_t fieldbus;
		ioc_ref_t io_ref1;
		ioc_ref_t io_ref2;
		ioc_ref_t preset;
	} ioc_refs_t;

	typedef struct packed {
		logic [3:0] logic_code;
		logic [2:0] src2;
		logic [2:0] src1;
	} ioc_comb_cfg_t;

	typedef enum logic {IOC_STOPPED, IOC_RUNNING} ioc_run_t;

	// Clamp a wide result into the reference range
	function automatic ioc_ref_t ioc_sat(input logic signed [31:0] v);
		ioc_ref_t r;
		r = v[15:0];
		if (v > `IOC_REF_MAX) begin
			r = ioc_ref_t'(`IOC_REF_MAX);
		end else if (v < `IOC_REF_MIN) begin
			r = ioc_ref_t'(`IOC_REF_MIN);
		end
		return r;
	endfunction : ioc_sat

	// Pick one digital input; zero selects nothing
	function automatic logic ioc_di_pick(input logic [`IOC_DI_W-1:0] di, input logic [3:0] sel);
		logic r;
		r = 1'b0;
		if (sel != 4'h0 && sel <= 4'(`IOC_DI_W)) begin
			r = di[3'(sel - 4'h1)];
		end
		return r;
	endfunction : ioc_di_pick

endpackage : ioc_pkg

// ---- verilog/ioc_ref_comb.sv ----
// Reference combiner: two selected sources joined into one registered reference.
// Assumes synchronous reference inputs and configuration held in the parent.
`timescale 1ns/10ps
`include "ioc_defs.svh"

module ioc_ref_comb #(
	parameter bit HAS_TOGGLE = 1'b0
) (
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_b_i,
	// Sources and setup
	input ioc_pkg::ioc_refs_t refs_i,
	input ioc_pkg::ioc_comb_cfg_t cfg_i,
	input wire logic toggle_i,
	// Result
	output ioc_pkg::ioc_ref_t ref_o
);
	import ioc_pkg::*;

	ioc_ref_t src_a, src_b, ref_d, ref_q;
	logic signed [31:0] prod;
	logic signed [16:0] quo;

	function automatic ioc_ref_t pick_src(input ioc_refs_t refs, input logic [2:0] sel);
		ioc_ref_t r;
		r = '0;
		case (sel)
			`IOC_SRC_FIELDBUS: r = refs.fieldbus;
			`IOC_SRC_IO1: r = refs.io_ref1;
			`IOC_SRC_IO2: r = refs.io_ref2;
			`IOC_SRC_PRESET: r = refs.preset;
			default: r = '0;
		endcase
		return r;
	endfunction : pick_src

	always_comb begin
		src_a = pick_src(refs_i, cfg_i.src1); // [R7] [R6]
		src_b = pick_src(refs_i, cfg_i.src2); // [R7] [R6]
		prod = src_a * src_b;
		// Signed zero keeps the whole divide signed
		quo = (src_b == '0) ? 17'sd0 : 17'(src_a) / 17'(src_b); // [R15]
		case (cfg_i.logic_code)
			`IOC_LOGIC_SRC1: ref_d = src_a; // [R8]
			`IOC_LOGIC_SRC2: ref_d = src_b; // [R8]
			`IOC_LOGIC_SUM: ref_d = ioc_sat(32'(src_a) + 32'(src_b)); // [R9]
			`IOC_LOGIC_SUB: ref_d = ioc_sat(32'(src_a) - 32'(src_b)); // [R9]
			`IOC_LOGIC_DIV: ref_d = ioc_sat(32'(quo)); // [R9]
			`IOC_LOGIC_MUL: ref_d = ioc_sat(prod); // [R9]
			`IOC_LOGIC_MAX: ref_d = (src_a > src_b) ? src_a : src_b; // [R10]
			`IOC_LOGIC_MIN: ref_d = (src_a < src_b) ? src_a : src_b; // [R10]
			`IOC_LOGIC_TOGGLE: ref_d = (HAS_TOGGLE && toggle_i) ? src_b : src_a; // [R11] [R12] [R13]
			default: ref_d = src_a;
		endcase
	end

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ref_q <= '0;
		end else begin
			ref_q <= ref_d;
		end
	end

	assign ref_o = ref_q;

	div_zero_a: assert property (@(posedge clock_i) disable iff (!rst_b_i) // [R15]
		(cfg_i.logic_code == `IOC_LOGIC_DIV && src_b == '0) |=> ref_o == '0)
		else $error("division by zero source did not give zero");

	toggle_pass_a: assert property (@(posedge clock_i) disable iff (!rst_b_i) // [R12]
		(cfg_i.logic_code == `IOC_LOGIC_TOGGLE) |=>
		ref_o == ((HAS_TOGGLE && $past(toggle_i)) ? $past(src_b) : $past(src_a)))
		else $error("toggle selection passed the wrong source");

	sum_path_a: assert property (@(posedge clock_i) disable iff (!rst_b_i) // [R9]
		(cfg_i.logic_code == `IOC_LOGIC_SUM && src_a == '0) |=> ref_o == $past(src_b))
		else $error("sum with zero source one is not source two");

endmodule : ioc_ref_comb

// ---- verilog/ioc_cmd_ref.sv ----
// I/O command and reference selection top: start modes, reverse, fault reset,
// and the speed and torque reference combiners behind a plain register port.
// Assumes digital inputs and stop command synchronous to clock_i.
//
// What this block does
// R1: Mode 0: start follows input level exactly
// R2: Mode 1: edge latch, stop ignored while input true
// R3: Mode 2: edge latch, stop always clears
// R4: Start mode resets to level-held start
// R5: Reverse only inverts reference, never starts
// R6: Each reference built from two selected sources
// R7: Source codes: none, fieldbus, ref1, ref2, preset
// R8: Codes 0 and 1 pass one source
// R9: Codes 2-5: sum, difference, quotient, product
// R10: Code 6 maximum, code 7 minimum
// R11: Speed combiner alone accepts toggle code 8
// R12: Toggle low passes source one, high two
// R13: Torque codes 0-7 only; defaults source one
// R14: Fault reset from one selected digital input
// R15: Division by zero source gives zero
// R16: Start edge compares input with previous cycle
`timescale 1ns/10ps
`include "ioc_defs.svh"

module ioc_cmd_ref (
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_b_i,
	// Register port
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic we_i,
	input wire logic re_i,
	output logic [31:0] rdata_o,
	// Drive inputs
	input wire logic [`IOC_DI_W-1:0] di_i,
	input wire logic stop_cmd_i,
	input ioc_pkg::ioc_refs_t refs_i,
	// Commands and references
	output logic start_cmd_o,
	output logic reverse_o,
	output logic fault_reset_o,
	output ioc_pkg::ioc_ref_t speed_ref_o,
	output ioc_pkg::ioc_ref_t torque_ref_o
);
	import ioc_pkg::*;

	// Configuration state
	logic [1:0] start_mode_q, start_mode_d;
	logic [3:0] start_sel_q, start_sel_d;
	logic [3:0] rev_sel_q, rev_sel_d;
	logic [3:0] rst_sel_q, rst_sel_d;
	logic [3:0] tog_sel_q, tog_sel_d;
	ioc_comb_cfg_t spd_cfg_q, spd_cfg_d;
	ioc_comb_cfg_t trq_cfg_q, trq_cfg_d;

	// Input and command state
	logic [`IOC_DI_W-1:0] di_q, di_d;
	logic start_prev_q, start_prev_d;
	ioc_run_t run_q, run_d;
	logic rev_q, rev_d;
	logic frst_q, frst_d;
	logic start_in, start_rise, rev_in, frst_in, tog_in;

	// Reference state
	ioc_ref_t spd_raw, trq_raw;
	ioc_ref_t speed_ref_q, speed_ref_d;
	ioc_ref_t torque_ref_q, torque_ref_d;

	// Read data
	logic [31:0] rdata_q, rdata_d;

	// Configuration writes
	always_comb begin
		start_mode_d = start_mode_q;
		start_sel_d = start_sel_q;
		rev_sel_d = rev_sel_q;
		rst_sel_d = rst_sel_q;
		tog_sel_d = tog_sel_q;
		spd_cfg_d = spd_cfg_q;
		trq_cfg_d = trq_cfg_q;
		if (we_i) begin
			case (addr_i)
				`IOC_ADDR_CMD_CFG: begin
					start_sel_d = wdata_i[`IOC_F_START_SEL];
					rev_sel_d = wdata_i[`IOC_F_REV_SEL];
					rst_sel_d = wdata_i[`IOC_F_RST_SEL]; // [R14]
					tog_sel_d = wdata_i[`IOC_F_TOG_SEL];
					start_mode_d = wdata_i[`IOC_F_START_MODE];
				end
				`IOC_ADDR_SPD_CFG: begin
					spd_cfg_d.src1 = wdata_i[`IOC_F_SRC1];
					spd_cfg_d.src2 = wdata_i[`IOC_F_SRC2];
					spd_cfg_d.logic_code = wdata_i[`IOC_F_LOGIC]; // [R11]
				end
				`IOC_ADDR_TRQ_CFG: begin
					trq_cfg_d.src1 = wdata_i[`IOC_F_SRC1];
					trq_cfg_d.src2 = wdata_i[`IOC_F_SRC2];
					trq_cfg_d.logic_code = {1'b0, wdata_i[`IOC_F_TRQ_LOGIC]}; // [R13]
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			start_mode_q <= `IOC_RST_START_MODE; // [R4]
			start_sel_q <= `IOC_RST_DI_SEL;
			rev_sel_q <= `IOC_RST_DI_SEL;
			rst_sel_q <= `IOC_RST_DI_SEL;
			tog_sel_q <= `IOC_RST_DI_SEL;
			spd_cfg_q <= '{logic_code: `IOC_RST_LOGIC, src2: `IOC_RST_SRC2, src1: `IOC_RST_SRC1};
			trq_cfg_q <= '{logic_code: `IOC_RST_LOGIC, src2: `IOC_RST_SRC2, src1: `IOC_RST_SRC1}; // [R13]
		end else begin
			start_mode_q <= start_mode_d;
			start_sel_q <= start_sel_d;
			rev_sel_q <= rev_sel_d;
			rst_sel_q <= rst_sel_d;
			tog_sel_q <= tog_sel_d;
			spd_cfg_q <= spd_cfg_d;
			trq_cfg_q <= trq_cfg_d;
		end
	end

	// Start, reverse and fault reset commands
	always_comb begin
		di_d = di_i;
		start_in = ioc_di_pick(di_q, start_sel_q);
		rev_in = ioc_di_pick(di_q, rev_sel_q);
		frst_in = ioc_di_pick(di_q, rst_sel_q); // [R14]
		tog_in = ioc_di_pick(di_q, tog_sel_q);
		start_prev_d = start_in;
		start_rise = start_in & ~start_prev_q; // [R16]
		rev_d = rev_in;
		frst_d = frst_in; // [R14]
		run_d = run_q;
		unique case (start_mode_q)
			`IOC_MODE_LEVEL: begin
				run_d = start_in ? IOC_RUNNING : IOC_STOPPED; // [R1]
			end
			`IOC_MODE_EDGE: begin
				if (start_rise) begin
					run_d = IOC_RUNNING; // [R2]
				end else if (stop_cmd_i && !start_in) begin
					run_d = IOC_STOPPED; // [R2]
				end
			end
			`IOC_MODE_PULSE: begin
				if (stop_cmd_i) begin
					run_d = IOC_STOPPED; // [R3]
				end else if (start_rise) begin
					run_d = IOC_RUNNING; // [R3]
				end
			end
			default: begin
				run_d = start_in ? IOC_RUNNING : IOC_STOPPED;
			end
		endcase
	end

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			di_q <= '0;
			start_prev_q <= 1'b0;
			run_q <= IOC_STOPPED;
			rev_q <= 1'b0;
			frst_q <= 1'b0;
		end else begin
			di_q <= di_d;
			start_prev_q <= start_prev_d;
			run_q <= run_d;
			rev_q <= rev_d;
			frst_q <= frst_d;
		end
	end

	assign start_cmd_o = (run_q == IOC_RUNNING);
	assign reverse_o = rev_q;
	assign fault_reset_o = frst_q;

	// Reference combiners
	ioc_ref_comb #(
		.HAS_TOGGLE(1'b1)
	) u_speed_comb (
		.clock_i(clock_i),
		.rst_b_i(rst_b_i),
		.refs_i(refs_i),
		.cfg_i(spd_cfg_q),
		.toggle_i(tog_in), // [R12]
		.ref_o(spd_raw)
	);

	ioc_ref_comb #(
		.HAS_TOGGLE(1'b0)
	) u_torque_comb (
		.clock_i(clock_i),
		.rst_b_i(rst_b_i),
		.refs_i(refs_i),
		.cfg_i(trq_cfg_q),
		.toggle_i(1'b0), // [R13]
		.ref_o(trq_raw)
	);

	// Reverse turns the speed reference round and does nothing else
	always_comb begin
		speed_ref_d = rev_in ? ioc_sat(-32'(spd_raw)) : spd_raw; // [R5]
		torque_ref_d = trq_raw;
	end

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			speed_ref_q <= '0;
			torque_ref_q <= '0;
		end else begin
			speed_ref_q <= speed_ref_d;
			torque_ref_q <= torque_ref_d;
		end
	end

	assign speed_ref_o = speed_ref_q;
	assign torque_ref_o = torque_ref_q;

	// Register reads
	always_comb begin
		rdata_d = '0;
		if (re_i) begin
			case (addr_i)
				`IOC_ADDR_CMD_CFG: begin
					rdata_d[`IOC_F_START_SEL] = start_sel_q;
					rdata_d[`IOC_F_REV_SEL] = rev_sel_q;
					rdata_d[`IOC_F_RST_SEL] = rst_sel_q;
					rdata_d[`IOC_F_TOG_SEL] = tog_sel_q;
					rdata_d[`IOC_F_START_MODE] = start_mode_q;
				end
				`IOC_ADDR_SPD_CFG: begin
					rdata_d[`IOC_F_SRC1] = spd_cfg_q.src1;
					rdata_d[`IOC_F_SRC2] = spd_cfg_q.src2;
					rdata_d[`IOC_F_LOGIC] = spd_cfg_q.logic_code;
				end
				`IOC_ADDR_TRQ_CFG: begin
					rdata_d[`IOC_F_SRC1] = trq_cfg_q.src1;
					rdata_d[`IOC_F_SRC2] = trq_cfg_q.src2;
					rdata_d[`IOC_F_TRQ_LOGIC] = trq_cfg_q.logic_code[2:0];
				end
				`IOC_ADDR_STATUS: begin
					rdata_d[`IOC_B_START] = start_cmd_o;
					rdata_d[`IOC_B_REV] = rev_q;
					rdata_d[`IOC_B_FRST] = frst_q;
					rdata_d[`IOC_B_TOG] = tog_in;
					rdata_d[`IOC_F_DI] = di_q;
				end
				`IOC_ADDR_SPD_REF: begin
					rdata_d[15:0] = speed_ref_q;
				end
				`IOC_ADDR_TRQ_REF: begin
					rdata_d[15:0] = torque_ref_q;
				end
				default: begin
					rdata_d = '0;
				end
			endcase
		end
	end

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rdata_q <= '0;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign rdata_o = rdata_q;

	// Checks
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!rst_b_i);

	logic cfg_wr;
	assign cfg_wr = we_i && (addr_i == `IOC_ADDR_CMD_CFG);

	sequence edge_latched_s;
		(start_mode_q == `IOC_MODE_EDGE) && start_rise && !cfg_wr;
	endsequence

	sequence input_released_s;
		(!start_in && !stop_cmd_i && !cfg_wr)[*2];
	endsequence

	level_start_a: assert property ( // [R1]
		(start_mode_q == `IOC_MODE_LEVEL) |=> start_cmd_o == $past(start_in))
		else $error("level start does not follow the input");

	edge_latch_a: assert property ( // [R2]
		edge_latched_s |=> start_cmd_o)
		else $error("edge start not latched");

	edge_hold_a: assert property ( // [R2]
		edge_latched_s ##1 input_released_s |=> start_cmd_o)
		else $error("edge start dropped without stop");

	edge_over_stop_a: assert property ( // [R2]
		((start_mode_q == `IOC_MODE_EDGE) && start_cmd_o && start_in && !cfg_wr)
		|=> start_cmd_o)
		else $error("edge start cleared while input true");

	pulse_stop_a: assert property ( // [R3]
		((start_mode_q == `IOC_MODE_PULSE) && stop_cmd_i) |=> !start_cmd_o)
		else $error("pulse start not cleared by stop");

	reset_mode_a: assert property ( // [R4]
		$rose(rst_b_i) |-> (start_mode_q == `IOC_MODE_LEVEL) && !start_cmd_o)
		else $error("start mode not level after reset");

	start_cause_a: assert property ( // [R5]
		$rose(start_cmd_o) |-> $past(start_in))
		else $error("start rose without the start input");

	reverse_sign_a: assert property ( // [R5]
		(rev_in && spd_raw != ioc_ref_t'(`IOC_REF_MIN)) |=> speed_ref_o == -$past(spd_raw))
		else $error("reverse did not invert the speed reference");

	fault_reset_a: assert property ( // [R14]
		frst_in |=> fault_reset_o)
		else $error("fault reset input not forwarded");

	torque_code_a: assert property ( // [R13]
		trq_cfg_q.logic_code[3] == 1'b0)
		else $error("torque combiner holds a code above seven");

	edge_detect_a: assert property ( // [R16]
		start_rise |-> start_in && !$past(start_in))
		else $error("start edge not against the previous cycle");

	read_once_a: assert property (
		!re_i |=> rdata_o == '0)
		else $error("read data outside the read answer cycle");

endmodule : ioc_cmd_ref

// ---- bench/ioc_src_model.sv ----
// Far side model: digital inputs, stop command and reference sources.
// Assumes the bench loads values just after a rising edge.
`timescale 1ns/10ps

module ioc_src_model (
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_b_i,
	// Load requests
	input wire logic load_i,
	input wire logic [7:0] di_set_i,
	input wire logic stop_set_i,
	input ioc_pkg::ioc_refs_t refs_set_i,
	// Toward the block
	output logic [7:0] di_o,
	output logic stop_o,
	output ioc_pkg::ioc_refs_t refs_o
);
	import ioc_pkg::*;
	// Sources move only on a clock edge
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			di_o <= 8'h00;
			stop_o <= 1'b0;
			refs_o <= '0;
		end else begin
			stop_o <= stop_set_i;
			if (load_i) begin
				di_o <= di_set_i;
				refs_o <= refs_set_i;
			end
		end
	end
endmodule : ioc_src_model

// ---- bench/testbench.sv ----
// Self-checking bench: registers, start modes and references.
// Assumes the source model and the register map of the block.
`timescale 1ns/10ps
`include "ioc_defs.svh"

module testbench;
	import ioc_pkg::*;
	logic clock_i, rst_b_i, we_i, re_i, load, stop_set, stop_cmd_i;
	logic start_cmd_o, reverse_o, fault_reset_o;
	logic [7:0] addr_i, di_i, di_set, d;
	logic [31:0] wdata_i, rdata_o, v;
	logic [2:0] k, s1, s2;
	ioc_refs_t refs_i, refs_set, r;
	ioc_ref_t speed_ref_o, torque_ref_o, e;
	logic [2:0] kq[$];
	logic [31:0] vq[$];
	int n_errors = 0;
	int tests_run = 0;

	ioc_cmd_ref ioc_cmd_ref_inst (.clock_i(clock_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .di_i(di_i),
		.stop_cmd_i(stop_cmd_i), .refs_i(refs_i), .start_cmd_o(start_cmd_o),
		.reverse_o(reverse_o), .fault_reset_o(fault_reset_o),
		.speed_ref_o(speed_ref_o), .torque_ref_o(torque_ref_o));
	ioc_src_model ioc_src_model_inst (.clock_i(clock_i), .rst_b_i(rst_b_i), .load_i(load),
		.di_set_i(di_set), .stop_set_i(stop_set), .refs_set_i(refs_set), .di_o(di_i),
		.stop_o(stop_cmd_i), .refs_o(refs_i));

	initial begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end

	function automatic ioc_ref_t sat(input longint x);
		if (x > 32767) return 16'sh7fff;
		if (x < -32768) return 16'sh8000;
		return ioc_ref_t'(x);
	endfunction : sat

	function automatic longint pick(input logic [2:0] c, input ioc_refs_t rf);
		case (c)
			3'h2: return rf.fieldbus;
			3'h3: return rf.io_ref1;
			3'h4: return rf.io_ref2;
			3'h5: return rf.preset;
			default: return 0;
		endcase
	endfunction : pick

	function automatic ioc_ref_t comb(input logic [3:0] c, input logic [2:0] a1,
		input logic [2:0] a2, input ioc_refs_t rf, input logic tog);
		longint a;
		longint b;
		a = pick(a1, rf);
		b = pick(a2, rf);
		case (c)
			4'h1: a = b;
			4'h2: a = a + b;
			4'h3: a = a - b;
			4'h4: a = (b == 0) ? 0 : a / b;
			4'h5: a = a * b;
			4'h6: a = (a > b) ? a : b;
			4'h7: a = (a < b) ? a : b;
			4'h8: a = tog ? b : a;
			default: ;
		endcase
		return sat(a);
	endfunction : comb

	task automatic summarize();
		if (n_errors == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : summarize

	task automatic cmp_r(input string n, input ioc_ref_t ex, input ioc_ref_t g);
		tests_run++;
		if (g !== ex) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", n, ex, g);
		end
	endtask : cmp_r

	task automatic cmp_b(input string n, input logic ex, input logic g);
		tests_run++;
		if (g !== ex) begin
			n_errors++;
			$display("ERROR %s expected %b seen %b", n, ex, g);
		end
	endtask : cmp_b

	task automatic cmp_w(input string n, input logic [31:0] ex, input logic [31:0] g);
		tests_run++;
		if (g !== ex) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", n, ex, g);
		end
	endtask : cmp_w

	task automatic note(input logic [2:0] kn, input logic [31:0] vn);
		kq.push_back(kn);
		vq.push_back(vn);
	endtask : note

	task automatic wr(input logic [7:0] a, input logic [31:0] wd);
		@(posedge clock_i);
		addr_i <= a;
		wdata_i <= wd;
		we_i <= 1'b1;
		@(posedge clock_i);
		we_i <= 1'b0;
	endtask : wr

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [31:0] ex);
		@(posedge clock_i);
		addr_i <= a;
		re_i <= 1'b1;
		@(posedge clock_i);
		re_i <= 1'b0;
		note(3'd5, ex);
	endtask : rd

	task automatic apply(input logic [7:0] dv, input ioc_refs_t rv);
		@(posedge clock_i);
		load <= 1'b1;
		di_set <= dv;
		refs_set <= rv;
		@(posedge clock_i);
		load <= 1'b0;
		repeat (4) @(posedge clock_i);
	endtask : apply

	task automatic stp();
		@(posedge clock_i);
		stop_set <= 1'b1;
		@(posedge clock_i);
		stop_set <= 1'b0;
		repeat (3) @(posedge clock_i);
	endtask : stp

	// Watcher: every pending note is due in the current cycle
	always @(negedge clock_i) begin
		while (kq.size() > 0) begin
			k = kq.pop_front();
			v = vq.pop_front();
			case (k)
				3'd0: cmp_r("speed", v[15:0], speed_ref_o);
				3'd1: cmp_r("torque", v[15:0], torque_ref_o);
				3'd2: cmp_b("start", v[0], start_cmd_o);
				3'd3: cmp_b("reverse", v[0], reverse_o);
				3'd4: cmp_b("fault_reset", v[0], fault_reset_o);
				default: cmp_w("rdata", v, rdata_o);
			endcase
		end
	end

	initial begin
		repeat (20000) @(posedge clock_i);
		n_errors++;
		summarize();
	end

	initial begin
		rst_b_i = 1'b0;
		addr_i = 8'h00;
		wdata_i = 32'h0;
		we_i = 1'b0;
		re_i = 1'b0;
		load = 1'b0;
		stop_set = 1'b0;
		di_set = 8'h00;
		refs_set = '0;
		void'($urandom(32'ha1e9d7db));
		repeat (20) @(posedge clock_i);
		rst_b_i <= 1'b1;
		rd(`IOC_ADDR_CMD_CFG, 32'h0);
		rd(`IOC_ADDR_SPD_CFG, 32'h3);
		rd(`IOC_ADDR_TRQ_CFG, 32'h3);
		wr(8'h20, 32'hffffffff);
		rd(8'h20, 32'h0);
		rd(`IOC_ADDR_CMD_CFG, 32'h0);
		r = {$urandom, $urandom};
		apply(8'h00, r);
		note(3'd0, {16'h0, r.io_ref1});
		note(3'd1, {16'h0, r.io_ref1});
		// Start in1, toggle in2, reverse in3, fault reset in4
		wr(`IOC_ADDR_CMD_CFG, 32'h0000_2431);
		for (int i = 0; i < 27; i++) begin
			s1 = 3'($urandom);
			s2 = (i == 4) ? 3'h0 : 3'($urandom);
			r = {$urandom, $urandom};
			d = 8'($urandom);
			wr(`IOC_ADDR_SPD_CFG, {20'h0, 4'(i % 16), 1'b0, s2, 1'b0, s1});
			wr(`IOC_ADDR_TRQ_CFG, {20'h0, 4'(i % 8), 1'b0, s2, 1'b0, s1});
			apply(d, r);
			e = comb(4'(i % 16), s1, s2, r, d[1]);
			if (d[2]) e = sat(-longint'(e));
			note(3'd0, {16'h0, e});
			note(3'd1, {16'h0, comb(4'(i % 8), s1, s2, r, d[1])});
			note(3'd2, {31'h0, d[0]});
			note(3'd3, {31'h0, d[2]});
			note(3'd4, {31'h0, d[3]});
			rd(`IOC_ADDR_STATUS, {16'h0, d, 4'h0, d[1], d[3], d[2], d[0]});
			rd(`IOC_ADDR_SPD_REF, {16'h0, e});
			rd(`IOC_ADDR_TRQ_REF, {16'h0, comb(4'(i % 8), s1, s2, r, d[1])});
		end
		apply(8'h00, r);
		wr(`IOC_ADDR_CMD_CFG, 32'h0001_2431);
		apply(8'h04, r);
		note(3'd2, 32'h0);
		apply(8'h01, r);
		note(3'd2, 32'h1);
		stp();
		note(3'd2, 32'h1);
		apply(8'h00, r);
		note(3'd2, 32'h1);
		stp();
		note(3'd2, 32'h0);
		wr(`IOC_ADDR_CMD_CFG, 32'h0002_2431);
		apply(8'h01, r);
		note(3'd2, 32'h1);
		stp();
		note(3'd2, 32'h0);
		wr(`IOC_ADDR_CMD_CFG, 32'h0000_2431);
		repeat (3) @(posedge clock_i);
		note(3'd2, 32'h1);
		// Mode 3 follows the input level like mode 0
		wr(`IOC_ADDR_CMD_CFG, 32'h0003_2431);
		apply(8'h00, r);
		note(3'd2, 32'h0);
		apply(8'h01, r);
		note(3'd2, 32'h1);
		repeat (3) @(posedge clock_i);
		summarize();
	end
endmodule : testbench
